//--- shared/qgfc_pkg.sv
// Shared constants, field layouts and types of the quad gate fault control block
package qgfc_pkg;

  localparam int NCH           = 4;
  localparam int WORD_W        = 8;
  localparam int BIT_CNT_W     = 4;
  localparam int BLANK_W       = 10;
  localparam int FILT_W        = 5;

  // System clock period
  localparam int CLK_PERIOD_NS = 25;

  // Turn-on blanking times at their upper limits, so monitoring never starts early
  localparam int T_ON00_NS     = 3400;
  localparam int T_ON01_NS     = 5900;
  localparam int T_ON10_NS     = 11200;
  localparam int T_ON11_NS     = 22300;
  localparam logic [BLANK_W-1:0] T_ON00_CYC = BLANK_W'(T_ON00_NS / CLK_PERIOD_NS);
  localparam logic [BLANK_W-1:0] T_ON01_CYC = BLANK_W'(T_ON01_NS / CLK_PERIOD_NS);
  localparam logic [BLANK_W-1:0] T_ON10_CYC = BLANK_W'(T_ON10_NS / CLK_PERIOD_NS);
  localparam logic [BLANK_W-1:0] T_ON11_CYC = BLANK_W'(T_ON11_NS / CLK_PERIOD_NS);

  // Fault filter time at its minimum, rounded up to whole cycles
  localparam int T_FF_NS       = 700;
  localparam logic [FILT_W-1:0] T_FF_CYC =
    FILT_W'((T_FF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Reset values
  localparam logic [1:0] BLANK_SEL_RST = 2'h0;
  localparam logic [1:0] ADDR_RST      = 2'h0;

  // Command word as shifted in, MSB first
  typedef struct packed {
    logic [1:0] addr;
    logic       rd_en;
    logic       mask;
    logic       clr;
    logic [1:0] blank_sel;
    logic       gate;
  } qgfc_cmd_type;

  // Fault word as shifted out, MSB first
  typedef struct packed {
    logic [1:0] addr;
    logic       write_flag_n;
    logic       cp_uv;
    logic       therm;
    logic       open_load_fault;
    logic       short_battery_fault;
    logic       stg;
  } qgfc_flt_type;

  function automatic logic [BLANK_W-1:0] qgfc_blank_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    qgfc_blank_cycles = T_ON00_CYC;
      2'h1:    qgfc_blank_cycles = T_ON01_CYC;
      2'h2:    qgfc_blank_cycles = T_ON10_CYC;
      default: qgfc_blank_cycles = T_ON11_CYC;
    endcase
  endfunction

endpackage

//--- hdl/qgfc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module qgfc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      meta_r <= RST_VAL;
      o_q    <= RST_VAL;
    end
    else
    begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end

endmodule

//--- hdl/qgfc_top.sv
// Quad gate driver control: serial port, fault latching and global gate gating
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] Serial port reaches one 8-bit command register and one 8-bit fault word.
// [RULE2] Gate is on when serial gate bit or discrete input is high.
// [RULE3] Command bits D2:D1 pick one of four turn-on blanking times per channel.
// [RULE4] Blanking selection resets to code 00, the shortest time.
// [RULE5] Clear bit with a channel selected clears that channel's latched faults.
// [RULE6] Clearing touches only the addressed channel.
// [RULE7] After clearing, the gate follows its command again so faults can reappear.
// [RULE8] Mask bit set ignores short-to-battery and open-load; clear registers them.
// [RULE9] Short-to-ground faults are never masked.
// [RULE10] Enable pin low with no faults: gates pulled low, fault pin high.
// [RULE11] Thermal warning pulls fault pin low; gates keep working.
// [RULE12] Masked off-state faults with enable high leave fault pin high, gates running.
// [RULE13] Latched short-to-ground forces its gate off and fault pin low.
// [RULE14] Charge pump undervoltage turns all gates off, fault pin low, regulator on.
// [RULE15] Logic undervoltage turns all gates off, fault pin low, pump and regulator on.
// [RULE16] Sleep pin low: gates released, pump and regulator off, fault pin low.
// [RULE17] Bits D7:D6 address channels 1 to 4 as codes 00 to 11.
// [RULE18] Bit D5 low discards the word; high registers it.
// [RULE19] Unmasked off-state source high after blanking latches short-to-battery, gate disabled.
// [RULE20] Faults register only if present longer than the filter time after blanking.
// [RULE21] One transfer is an 8-bit frame under chip select, command in, faults out.
module qgfc_top
  import qgfc_pkg::*;
(
  input  wire logic           i_clk_sys,
  input  wire logic           i_nrst,
  input  wire logic           i_spi_sclk,
  input  wire logic           i_spi_cs_n,
  input  wire logic           i_spi_mosi,
  output logic                o_spi_miso,
  output logic                o_spi_miso_oe,
  input  wire logic           i_sleep_control_n,
  input  wire logic           i_gate_permit_pin,
  input  wire logic [NCH-1:0] i_discrete_gate_input,
  input  wire logic [NCH-1:0] i_stg_cmp,
  input  wire logic [NCH-1:0] i_stb_cmp,
  input  wire logic [NCH-1:0] i_ol_cmp,
  input  wire logic           i_thermal_warn,
  input  wire logic           i_cp_undervoltage_lockout,
  input  wire logic           i_vdd_undervoltage_lockout,
  output logic [NCH-1:0]      o_gate_drive_output,
  output logic [NCH-1:0]      o_gate_drive_oe,
  output logic                o_fault_flag_n,
  output logic                o_charge_pump_supply_en,
  output logic                o_internal_regulator_en
);

  localparam int SYNC_W = 8 + 4 * NCH;
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0,
                                            1'b0, 1'b0, 1'b0, {(4 * NCH){1'b0}}};

  // Synchronised pin levels
  logic [SYNC_W-1:0]  sync_q;
  logic               sclk_s;
  logic               cs_n_s;
  logic               mosi_s;
  logic               sleep_n_s;
  logic               permit_s;
  logic               therm_s;
  logic               cp_uv_s;
  logic               vdd_uv_s;
  logic [NCH-1:0]     din_s;
  logic [NCH-1:0]     stg_s;
  logic [NCH-1:0]     stb_s;
  logic [NCH-1:0]     ol_s;

  qgfc_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_d       ({i_spi_sclk, i_spi_cs_n, i_spi_mosi, i_sleep_control_n,
                 i_gate_permit_pin, i_thermal_warn, i_cp_undervoltage_lockout,
                 i_vdd_undervoltage_lockout, i_discrete_gate_input,
                 i_stg_cmp, i_stb_cmp, i_ol_cmp}),
    .o_q       (sync_q)
  );

  assign {sclk_s, cs_n_s, mosi_s, sleep_n_s, permit_s, therm_s, cp_uv_s,
          vdd_uv_s, din_s, stg_s, stb_s, ol_s} = sync_q;

  // Sleep acts as a reset of all control state
  logic               run;
  assign run = i_nrst && sleep_n_s;

  // Serial frame tracking
  logic               sclk_d_r;
  logic               cs_n_d_r;
  logic               sclk_rise;
  logic               sclk_fall;
  logic               cs_fall;
  logic               cs_rise;
  logic [WORD_W-1:0]  shift_in_r;
  logic [WORD_W-1:0]  shift_out_r;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  qgfc_cmd_type       cmd;
  qgfc_flt_type       flt_word;
  logic [1:0]         rd_addr_r;

  assign sclk_rise = sclk_s && !sclk_d_r;
  assign sclk_fall = !sclk_s && sclk_d_r;
  assign cs_fall   = !cs_n_s && cs_n_d_r;
  assign cs_rise   = cs_n_s && !cs_n_d_r;
  assign cmd       = qgfc_cmd_type'(shift_in_r);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  // Command bits shift in MSB first on rising clock edges
  always_ff @(posedge i_clk_sys)
  begin
    if (!run)
    begin
      shift_in_r <= '0;
      bit_cnt_r  <= '0;
    end
    else if (cs_fall)
    begin
      bit_cnt_r  <= '0;
    end
    else if (!cs_n_s && sclk_rise)
    begin
      shift_in_r <= {shift_in_r[WORD_W-2:0], mosi_s};
      if (bit_cnt_r != BIT_CNT_W'(WORD_W))
      begin
        bit_cnt_r <= bit_cnt_r + BIT_CNT_W'(1);
      end
    end
  end

  // Per-channel command state
  logic [NCH-1:0]     gate_cmd_r;
  logic [1:0]         blank_sel_r [NCH];
  logic [NCH-1:0]     mask_r;
  logic [NCH-1:0]     clr_pulse_r;
  logic               accept;

  // Frames shorter than 8 bits are dropped whole; longer ones keep the last 8 bits
  assign accept = cs_rise && (bit_cnt_r == BIT_CNT_W'(WORD_W)) && cmd.rd_en; // [RULE18] [RULE21] [RULE1]

  always_ff @(posedge i_clk_sys)
  begin
    if (!run)
    begin
      gate_cmd_r  <= '0;
      mask_r      <= '0;
      clr_pulse_r <= '0;
      rd_addr_r   <= ADDR_RST;
      for (int k = 0; k < NCH; k++)
      begin
        blank_sel_r[k] <= BLANK_SEL_RST; // [RULE4]
      end
    end
    else
    begin
      clr_pulse_r <= '0;
      if (accept)
      begin
        rd_addr_r                <= cmd.addr; // [RULE17]
        gate_cmd_r[cmd.addr]     <= cmd.gate;
        blank_sel_r[cmd.addr]    <= cmd.blank_sel; // [RULE3]
        mask_r[cmd.addr]         <= cmd.mask;
        clr_pulse_r[cmd.addr]    <= cmd.clr; // [RULE5] [RULE6]
      end
    end
  end

  // Global gate permission
  logic               global_ok;
  assign global_ok = permit_s && !cp_uv_s && !vdd_uv_s; // [RULE10] [RULE14] [RULE15]

  logic [NCH-1:0]     stg_flt;
  logic [NCH-1:0]     stb_flt;
  logic [NCH-1:0]     ol_flt;
  logic [NCH-1:0]     gate_on;
  logic [NCH-1:0]     ch_block;

  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      logic               stg_r;
      logic               stb_r;
      logic               ol_r;
      logic               on_d_r;
      logic [BLANK_W-1:0] blank_cnt_r;
      logic [FILT_W-1:0]  stg_filt_r;
      logic [FILT_W-1:0]  stb_filt_r;
      logic [FILT_W-1:0]  ol_filt_r;
      logic               blanked;
      logic               stg_hit;
      logic               stb_hit;
      logic               ol_hit;

      // Latched faults hold the gate off; masking releases off-state ones
      assign ch_block[c] = stg_r || ((stb_r || ol_r) && !mask_r[c]); // [RULE13] [RULE19] [RULE8]
      assign gate_on[c]  = (gate_cmd_r[c] || din_s[c]) && !ch_block[c] && global_ok; // [RULE2] [RULE7]

      // Turn-off blanking reuses the turn-on selection
      assign blanked = blank_cnt_r < qgfc_blank_cycles(blank_sel_r[c]);

      always_ff @(posedge i_clk_sys)
      begin
        if (!run)
        begin
          on_d_r      <= 1'b0;
          blank_cnt_r <= '0;
        end
        else
        begin
          on_d_r <= gate_on[c];
          if (gate_on[c] != on_d_r)
          begin
            blank_cnt_r <= '0;
          end
          else if (blanked)
          begin
            blank_cnt_r <= blank_cnt_r + BLANK_W'(1);
          end
        end
      end

      // Filters count consecutive samples after blanking
      always_ff @(posedge i_clk_sys)
      begin
        if (!run || blanked || (gate_on[c] != on_d_r))
        begin
          stg_filt_r <= '0;
          stb_filt_r <= '0;
          ol_filt_r  <= '0;
        end
        else
        begin
          stg_filt_r <= (on_d_r && stg_s[c] && stg_filt_r != T_FF_CYC) ?
                        stg_filt_r + FILT_W'(1) : (on_d_r && stg_s[c] ? stg_filt_r : '0); // [RULE20]
          stb_filt_r <= (!on_d_r && stb_s[c] && stb_filt_r != T_FF_CYC) ?
                        stb_filt_r + FILT_W'(1) : (!on_d_r && stb_s[c] ? stb_filt_r : '0); // [RULE20]
          ol_filt_r  <= (!on_d_r && ol_s[c] && ol_filt_r != T_FF_CYC) ?
                        ol_filt_r + FILT_W'(1) : (!on_d_r && ol_s[c] ? ol_filt_r : '0); // [RULE20]
        end
      end

      assign stg_hit = (stg_filt_r == T_FF_CYC) && on_d_r; // [RULE9]
      assign stb_hit = (stb_filt_r == T_FF_CYC) && !on_d_r && !mask_r[c]; // [RULE8] [RULE19]
      assign ol_hit  = (ol_filt_r == T_FF_CYC) && !on_d_r && !mask_r[c]; // [RULE8]

      // Detection wins over a clear in the same cycle
      always_ff @(posedge i_clk_sys)
      begin
        if (!run)
        begin
          stg_r <= 1'b0;
          stb_r <= 1'b0;
          ol_r  <= 1'b0;
        end
        else
        begin
          stg_r <= stg_hit || (stg_r && !clr_pulse_r[c]); // [RULE13] [RULE5]
          stb_r <= stb_hit || (stb_r && !clr_pulse_r[c]); // [RULE19] [RULE5]
          ol_r  <= ol_hit || (ol_r && !clr_pulse_r[c]); // [RULE5]
        end
      end

      assign stg_flt[c] = stg_r;
      assign stb_flt[c] = stb_r;
      assign ol_flt[c]  = ol_r;
    end
  endgenerate

  // Fault word for the most recently addressed channel
  always_comb
  begin
    flt_word                     = '0;
    flt_word.addr                = rd_addr_r;
    flt_word.write_flag_n        = 1'b0;
    flt_word.cp_uv               = cp_uv_s;
    flt_word.therm               = therm_s;
    flt_word.open_load_fault     = ol_flt[rd_addr_r];
    flt_word.short_battery_fault = stb_flt[rd_addr_r];
    flt_word.stg                 = stg_flt[rd_addr_r];
  end

  // Read data shifts out on falling edges, first bit ready at select
  always_ff @(posedge i_clk_sys)
  begin
    if (!run)
    begin
      shift_out_r <= '0;
    end
    else if (cs_fall)
    begin
      shift_out_r <= flt_word; // [RULE21] [RULE1]
    end
    else if (!cs_n_s && sclk_fall)
    begin
      shift_out_r <= {shift_out_r[WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_spi_miso    <= 1'b0;
      o_spi_miso_oe <= 1'b0;
    end
    else
    begin
      o_spi_miso    <= shift_out_r[WORD_W-1];
      o_spi_miso_oe <= !cs_n_s && sleep_n_s;
    end
  end

  // Unmasked off-state faults and thermal warning reach the fault pin
  logic               any_fault;
  assign any_fault = (|stg_flt) || (|((stb_flt | ol_flt) & ~mask_r)) || therm_s
                     || cp_uv_s || vdd_uv_s; // [RULE11] [RULE12] [RULE13] [RULE14] [RULE15]

  // Output stage
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_gate_drive_output     <= '0;
      o_gate_drive_oe         <= '0;
      o_fault_flag_n          <= 1'b0;
      o_charge_pump_supply_en <= 1'b0;
      o_internal_regulator_en <= 1'b0;
    end
    else if (!sleep_n_s)
    begin
      o_gate_drive_output     <= '0; // [RULE16]
      o_gate_drive_oe         <= '0;
      o_fault_flag_n          <= 1'b0;
      o_charge_pump_supply_en <= 1'b0;
      o_internal_regulator_en <= 1'b0;
    end
    else
    begin
      o_gate_drive_output     <= gate_on; // [RULE10] [RULE11] [RULE12]
      o_gate_drive_oe         <= '1;
      o_fault_flag_n          <= !any_fault; // [RULE10]
      o_charge_pump_supply_en <= 1'b1; // [RULE14] [RULE15]
      o_internal_regulator_en <= 1'b1;
    end
  end

endmodule

//--- dv/qgfc_checker.sv
// Port-level assertions for the quad gate fault control block
`timescale 1ns/1ps
module qgfc_checker
  import qgfc_pkg::*;
(
  input wire logic           i_clk_sys,
  input wire logic           i_nrst,
  input wire logic           i_spi_cs_n,
  input wire logic           i_sleep_control_n,
  input wire logic           i_gate_permit_pin,
  input wire logic [NCH-1:0] i_stg_cmp,
  input wire logic           i_thermal_warn,
  input wire logic           i_cp_undervoltage_lockout,
  input wire logic           i_vdd_undervoltage_lockout,
  input wire logic           o_spi_miso_oe,
  input wire logic [NCH-1:0] o_gate_drive_output,
  input wire logic [NCH-1:0] o_gate_drive_oe,
  input wire logic           o_fault_flag_n,
  input wire logic           o_charge_pump_supply_en,
  input wire logic           o_internal_regulator_en
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  logic [9:0] stg_cnt_r;
  // Saturates so a stuck gate is still flagged
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst || !(o_gate_drive_output[0] && i_stg_cmp[0]))
      stg_cnt_r <= '0;
    else if (stg_cnt_r != '1)
      stg_cnt_r <= stg_cnt_r + 10'h001;
  end
  // Longest blank plus filter, latch and output flop, with a small margin
  localparam logic [9:0] STG_CUT_MAX = 10'h3A2;
  always_comb
  begin
  end
  // Five cycles cover two sync flops and the output flop
  sequence s_asleep; (!i_sleep_control_n)[*5]; endsequence
  sequence s_awake; i_sleep_control_n[*5]; endsequence
  a_sleep_outputs:
    assert property (s_asleep |-> o_gate_drive_oe == 4'h0 && !o_fault_flag_n && !o_charge_pump_supply_en
      && !o_internal_regulator_en) else $error("sleep outputs wrong");
  a_awake_driven:
    assert property (s_awake |-> o_gate_drive_oe == 4'hF) else $error("gates undriven while awake");
  a_cp_uv_off:
    assert property ((i_sleep_control_n && i_cp_undervoltage_lockout)[*5] |-> o_gate_drive_output == 4'h0
      && !o_fault_flag_n && o_internal_regulator_en) else $error("pump undervoltage outputs wrong");
  a_vdd_uv_off:
    assert property ((i_sleep_control_n && i_vdd_undervoltage_lockout)[*5] |-> o_gate_drive_output == 4'h0
      && !o_fault_flag_n && o_charge_pump_supply_en && o_internal_regulator_en) else $error("logic uv wrong");
  a_permit_low:
    assert property ((!i_gate_permit_pin)[*5] |-> o_gate_drive_output == 4'h0) else $error("gate on unpermitted");
  a_thermal_flag:
    assert property (i_thermal_warn[*5] |-> !o_fault_flag_n) else $error("thermal not flagged");
  a_miso_released:
    assert property (i_spi_cs_n[*6] |-> !o_spi_miso_oe) else $error("miso driven while deselected");
  a_stg_cutoff:
    assert property (stg_cnt_r <= STG_CUT_MAX) else $error("shorted gate left on");
endmodule

bind qgfc_top qgfc_checker u_chk (.*);

//--- dv/qgfc_host.sv
// Host controller model driving the serial port
`timescale 1ns/1ps
module qgfc_host (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi,
  input  wire logic i_miso
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // Clock idles low; a count below 8 makes a frame that is dropped, a count above 8 keeps the last 8 bits
  task automatic xfer(input logic [7:0] cmd, input int nb, output logic [7:0] rsp);
    rsp = 8'h00;
    o_cs_n = 1'b0;
    #400;
    for (int i = nb - 1; i >= 0; i--)
    begin
      o_mosi = cmd[i % 8];
      #100 o_sclk = 1'b1;
      #100 rsp = {rsp[6:0], i_miso};
      o_sclk = 1'b0;
    end
    #200 o_cs_n = 1'b1;
    // Released line does not keep the last bit
    o_mosi = ~o_mosi;
    #2000;
  endtask
endmodule

//--- dv/test_qgfc_top.sv
// Self-checking bench for the quad gate fault control block
`timescale 1ns/1ps
module test_qgfc_top;
  import qgfc_pkg::*;
  logic       clk, nrst, sleep_n, permit, therm, cp_uv, vdd_uv;
  logic [3:0] din, stg, stb, ol, gate, oe;
  logic       sclk, cs_n, mosi, miso, miso_oe, flt_n, cp_en, reg_en;
  logic [7:0] exp_q[$], obs_q[$], rsp, e, o;
  string      nm_q[$], s;
  int         mismatches, checks_done, n;
  int         bl[4] = '{T_ON00_CYC, T_ON01_CYC, T_ON10_CYC, T_ON11_CYC};
  logic [15:0] rnd;

  qgfc_top uut (.i_clk_sys(clk), .i_nrst(nrst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
    .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_sleep_control_n(sleep_n), .i_gate_permit_pin(permit),
    .i_discrete_gate_input(din), .i_stg_cmp(stg), .i_stb_cmp(stb), .i_ol_cmp(ol), .i_thermal_warn(therm),
    .i_cp_undervoltage_lockout(cp_uv), .i_vdd_undervoltage_lockout(vdd_uv), .o_gate_drive_output(gate),
    .o_gate_drive_oe(oe), .o_fault_flag_n(flt_n), .o_charge_pump_supply_en(cp_en),
    .o_internal_regulator_en(reg_en));
  // Miso has a pull-up when released
  qgfc_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_oe ? miso : 1'b1));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] outs();
    return {gate, flt_n, cp_en, reg_en, 1'b0};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [7:0] ev, input logic [7:0] v);
    nm_q.push_back(nm);
    exp_q.push_back(ev);
    obs_q.push_back(v);
  endtask
  task automatic wait_gate(input int ch, input logic v);
    n = 0;
    while (gate[ch] !== v && n < 2000)
    begin
      cyc(1);
      n++;
    end
  endtask
  // Gate-on span up to the short-to-ground cut-off
  task automatic measure(input int ch, input int code);
    wait_gate(ch, 1'b1);
    wait_gate(ch, 1'b0);
    chk("blank_span", 8'h01, 8'(n >= bl[code] + 26 && n <= bl[code] + 34));
  endtask
  task automatic wrap_up();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always
  begin
    wait (obs_q.size() > 0);
    s = nm_q.pop_front();
    e = exp_q.pop_front();
    o = obs_q.pop_front();
    checks_done++;
    if (o !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, o);
    end
  end
  initial
  begin
    #2000000;
    mismatches++;
    wrap_up();
  end

  initial
  begin
    {nrst, therm, cp_uv, vdd_uv, din, stg, stb, ol} = '0;
    {sleep_n, permit} = 2'b11;
    rnd = 16'hDA42;
    cyc(4);
    nrst = 1'b1;
    permit = 1'b0;
    din = 4'hF;
    cyc(8);
    chk("permit_low", 8'h0E, outs());
    permit = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      din = rnd[3:0];
      cyc(8);
      chk("din_gates", {rnd[3:0], 4'hE}, outs());
    end
    din = 4'h0;
    stg = 4'h8;
    cyc(8);
    din = 4'h8;
    measure(3, 0);
    {din, stg} = '0;
    therm = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      host.xfer({c[1:0], 6'h29}, 8, rsp);
      chk("readback", {2'(c == 0 ? 0 : c - 1), 6'h08}, rsp);
      chk("ser_gates", {4'((2 << c) - 1), 4'h6}, outs());
    end
    therm = 1'b0;
    host.xfer(8'h00, 8, rsp);
    host.xfer(8'h20, 7, rsp);
    chk("refused", 8'hFE, outs());
    host.xfer(8'h31, 8, rsp);
    host.xfer(8'h71, 8, rsp);
    stg = 4'h3;
    cyc(20);
    chk("stg_filter", 8'hFE, outs());
    cyc(30);
    chk("stg_latch", 8'hC6, outs());
    host.xfer(8'h00, 8, rsp);
    chk("stg_masked_bit", 8'h41, rsp);
    stg = 4'h1;
    host.xfer(8'h79, 8, rsp);
    chk("clr_one", 8'hE6, outs());
    host.xfer(8'h39, 8, rsp);
    chk("reenable", 8'hFE, outs());
    cyc(150);
    chk("relatch", 8'hE6, outs());
    stg = 4'h4;
    host.xfer(8'h39, 8, rsp);
    cyc(60);
    for (int k = 0; k < 4; k++)
    fork
      host.xfer({2'h2, 3'h5, k[1:0], 1'b1}, 8, rsp);
      measure(2, k);
    join
    stg = 4'h0;
    host.xfer(8'hA8, 8, rsp);
    stb = 4'h8;
    host.xfer(8'hE0, 8, rsp);
    cyc(250);
    chk("stb_latch", 8'h36, outs());
    host.xfer(8'h00, 8, rsp);
    chk("stb_bit", 8'hC2, rsp);
    host.xfer(8'hF0, 8, rsp);
    chk("stb_masked", 8'h3E, outs());
    ol = 4'h8;
    din = 4'h8;
    cyc(250);
    chk("masked_run", 8'hBE, outs());
    din = 4'h0;
    cyc(250);
    chk("ol_masked", 8'h3E, outs());
    // Masked open load must not latch; the earlier short-to-battery bit stays
    host.xfer(8'h00, 8, rsp);
    chk("ol_bit", 8'hC2, rsp);
    {stb, ol} = '0;
    cp_uv = 1'b1;
    cyc(8);
    chk("cp_uv", 8'h02, outs() & 8'hFA);
    cp_uv = 1'b0;
    vdd_uv = 1'b1;
    cyc(8);
    chk("vdd_uv", 8'h06, outs());
    vdd_uv = 1'b0;
    sleep_n = 1'b0;
    cyc(8);
    chk("sleep", 8'h00, {oe, flt_n, cp_en, reg_en, 1'b0});
    sleep_n = 1'b1;
    cyc(8);
    chk("wake", 8'hF0, {oe, gate});
    cyc(4);
    wrap_up();
  end
endmodule
